// >>> design/sww_consts.svh
`ifndef SWW_CONSTS_SVH
`define SWW_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SWW_ADDR_W          12
`define SWW_OFS_STBY_CTRL   12'h000
`define SWW_OFS_STATUS      12'h004

// ----------------------------------------
// Field positions of standby_control
// ----------------------------------------
`define SWW_SOFT_STANDBY_SELECT_BIT        7
`define SWW_WSEL_MSB        6
`define SWW_WSEL_LSB        4
`define SWW_RSV_ONE_BIT     3
`define SWW_STBY_RESET      8'h08

// ----------------------------------------
// Wait counts in system clock states
// ----------------------------------------
`define SWW_WAIT_CODE0      8192
`define SWW_WAIT_CODE1      16384
`define SWW_WAIT_CODE2      32768
`define SWW_WAIT_CODE3      65536
`define SWW_WAIT_CODE4      131072
`define SWW_WAIT_CODE5      262144
`define SWW_WAIT_CODE7      16
`define SWW_CNT_W           19

`endif

// >>> design/sww_pkg.sv
package sww_pkg;

    // Power state, Gray coded along active-standby-wait and active-sleep-active
    typedef enum logic [1:0] {
        SWW_ACTIVE  = 2'b00,
        SWW_STANDBY = 2'b01,
        SWW_OSCWAIT = 2'b11,
        SWW_SLEEP   = 2'b10
    } sww_state_e;

    typedef logic [2:0] sww_wsel_t;

endpackage

// >>> design/sww_tmr_if.sv
`timescale 1ns/1ps
`include "sww_consts.svh"

interface sww_tmr_if;
    logic                    start;
    logic [`SWW_CNT_W-1:0]   limit;
    logic                    busy;
    logic                    done;

    modport ctrl  (output start, output limit, input busy, input done);
    modport timer (input start, input limit, output busy, output done);
endinterface

// >>> design/sww_wait_timer.sv
`timescale 1ns/1ps
`include "sww_consts.svh"

module sww_wait_timer
    import sww_pkg::*;
(
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  reset_n,
    // Control side
    sww_tmr_if.timer   tmr
);

    logic [`SWW_CNT_W-1:0] count_ff;
    logic                  busy_ff;
    logic                  done_ff;
    wire                   lastState = busy_ff && (count_ff == '0);

    // Counts limit states, then pulses done for one cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= lastState;
            if (tmr.start) begin
                count_ff <= tmr.limit - `SWW_CNT_W'(1);
                busy_ff  <= 1'b1;
            end else if (lastState) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                count_ff <= count_ff - `SWW_CNT_W'(1);
            end
        end
    end

    assign tmr.busy = busy_ff;
    assign tmr.done = done_ff;

endmodule

// >>> design/sww_standby_ctrl.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "sww_consts.svh"

// Notes on behaviour
// R1: Bits 6..4 of standby_control pick the clock settling wait used on an interrupt wakeup.
// R2: The wait-select field is read/write and clears to zero on reset.
// R3: Codes 000 to 101 give 8192, 16384, 32768, 65536, 131072 and 262144 states.
// R4: Code 111 gives 16 states; code 110 is reserved and must not be programmed.
// R5: With a crystal, software programs a wait of at least 8 ms at its clock rate.
// R6: With an external clock, software programs a wait of at least 2 ms.
// R7: Bit 3 resets to one, is read/write, and software always writes one to it.
// R8: Bits 2..0 always read zero and writes to them are ignored.
// R9: Bit 7 picks standby on a sleep request when one, plain sleep when zero; resets to zero.
// R10: On an interrupt wakeup the oscillator restarts and clocks return only after the wait.
module sww_standby_ctrl
    import sww_pkg::*;
#(
    parameter int unsigned WAIT_CODE0 = `SWW_WAIT_CODE0,
    parameter int unsigned WAIT_CODE1 = `SWW_WAIT_CODE1,
    parameter int unsigned WAIT_CODE2 = `SWW_WAIT_CODE2,
    parameter int unsigned WAIT_CODE3 = `SWW_WAIT_CODE3,
    parameter int unsigned WAIT_CODE4 = `SWW_WAIT_CODE4,
    parameter int unsigned WAIT_CODE5 = `SWW_WAIT_CODE5
)
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`SWW_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // CPU and wake sources
    input  wire logic                   sleepReq,
    input  wire logic                   extIrq,
    // Clock gating towards the chip
    output logic                        oscEnable,
    output logic                        cpuClkEnable,
    output logic                        periphClkEnable
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic       softStandbySelect_ff;
    sww_wsel_t  wakeWaitSel_ff;
    logic       rsvOne_ff;
    logic [31:0] prdata_ff;
    logic       pslverr_ff;

    localparam logic [7:0] STBY_RESET = `SWW_STBY_RESET;

    // ----------------------------------------
    // Wait-count lookup
    // ----------------------------------------
    // Reserved code 110 falls back to the longest wait so a bad write never shortens settling
    function automatic logic [`SWW_CNT_W-1:0] waitCount(input sww_wsel_t code);
        case (code)
            3'h0:    waitCount = `SWW_CNT_W'(WAIT_CODE0);     // [R3]
            3'h1:    waitCount = `SWW_CNT_W'(WAIT_CODE1);     // [R3]
            3'h2:    waitCount = `SWW_CNT_W'(WAIT_CODE2);     // [R3]
            3'h3:    waitCount = `SWW_CNT_W'(WAIT_CODE3);     // [R3]
            3'h4:    waitCount = `SWW_CNT_W'(WAIT_CODE4);     // [R3]
            3'h5:    waitCount = `SWW_CNT_W'(WAIT_CODE5);     // [R3]
            3'h7:    waitCount = `SWW_CNT_W'(`SWW_WAIT_CODE7); // [R4]
            default: waitCount = `SWW_CNT_W'(WAIT_CODE5);     // [R4]
        endcase
    endfunction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire        apbAccess = psel && penable;
    wire        hitCtrl   = (paddr == `SWW_OFS_STBY_CTRL);
    wire        hitStatus = (paddr == `SWW_OFS_STATUS);
    wire        hitAny    = hitCtrl || hitStatus;
    wire        wrCtrl    = apbAccess && pwrite && hitCtrl;
    wire        rdEdge    = apbAccess && !pwrite;

    sww_state_e state_ff;
    sww_state_e nxt_state;
    sww_tmr_if  tmr ();

    // Bits 2..0 are never stored, so they read zero
    wire [7:0] ctrlView = {softStandbySelect_ff, wakeWaitSel_ff, rsvOne_ff, 3'h0}; // [R8]
    wire [7:0] statView = {5'h00, tmr.busy, state_ff};
    wire [31:0] rdMux   = hitCtrl ? {24'h000000, ctrlView} :
                          hitStatus ? {24'h000000, statView} : 32'h00000000;

    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    // Zero wait states: data is captured on the setup edge and stands in the access cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= (psel && !penable && !pwrite) ? rdMux : prdata_ff;
            pslverr_ff <= psel && !penable && !hitAny;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            softStandbySelect_ff <= STBY_RESET[`SWW_SOFT_STANDBY_SELECT_BIT];               // [R9]
            wakeWaitSel_ff       <= STBY_RESET[`SWW_WSEL_MSB:`SWW_WSEL_LSB]; // [R2]
            rsvOne_ff            <= STBY_RESET[`SWW_RSV_ONE_BIT];            // [R7]
        end else if (wrCtrl) begin
            softStandbySelect_ff <= pwdata[`SWW_SOFT_STANDBY_SELECT_BIT];                 // [R9]
            wakeWaitSel_ff       <= pwdata[`SWW_WSEL_MSB:`SWW_WSEL_LSB];   // [R1] [R2]
            rsvOne_ff            <= pwdata[`SWW_RSV_ONE_BIT];              // [R7]
        end
    end

    // ----------------------------------------
    // Wake interrupt synchroniser
    // ----------------------------------------
    logic irqS1_ff;
    logic irqS2_ff;
    logic irqS3_ff;
    logic irqLevel_ff;

    // A change counts only once the second and third stages agree
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqS1_ff    <= 1'b0;
            irqS2_ff    <= 1'b0;
            irqS3_ff    <= 1'b0;
            irqLevel_ff <= 1'b0;
        end else begin
            irqS1_ff    <= extIrq;
            irqS2_ff    <= irqS1_ff;
            irqS3_ff    <= irqS2_ff;
            irqLevel_ff <= (irqS2_ff == irqS3_ff) ? irqS3_ff : irqLevel_ff;
        end
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    wire enterStandby = (state_ff == SWW_ACTIVE) && sleepReq && softStandbySelect_ff;
    wire enterSleep   = (state_ff == SWW_ACTIVE) && sleepReq && !softStandbySelect_ff;
    wire wakeStandby  = (state_ff == SWW_STANDBY) && irqLevel_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SWW_ACTIVE: begin
                if (enterStandby) begin
                    nxt_state = SWW_STANDBY;              // [R9]
                end else if (enterSleep) begin
                    nxt_state = SWW_SLEEP;                // [R9]
                end
            end
            SWW_SLEEP: begin
                if (irqLevel_ff) begin
                    nxt_state = SWW_ACTIVE;
                end
            end
            SWW_STANDBY: begin
                if (wakeStandby) begin
                    nxt_state = SWW_OSCWAIT;              // [R10]
                end
            end
            SWW_OSCWAIT: begin
                if (tmr.done) begin
                    nxt_state = SWW_ACTIVE;               // [R10]
                end
            end
            default: nxt_state = SWW_ACTIVE;
        endcase
    end

    // Restart the oscillator and start the settling count together
    assign tmr.start = wakeStandby;                        // [R10]
    assign tmr.limit = waitCount(wakeWaitSel_ff);          // [R1] [R3] [R4]

    sww_wait_timer u_wait_timer (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .tmr     (tmr)
    );

    // ----------------------------------------
    // Clock enables, registered from the next state
    // ----------------------------------------
    logic nxt_oscEnable;
    logic nxt_cpuClk;
    logic nxt_periphClk;
    logic oscEnable_ff;
    logic cpuClk_ff;
    logic periphClk_ff;

    assign nxt_oscEnable = (nxt_state != SWW_STANDBY);
    assign nxt_cpuClk    = (nxt_state == SWW_ACTIVE);  // [R10]
    assign nxt_periphClk = (nxt_state == SWW_ACTIVE) || (nxt_state == SWW_SLEEP);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= SWW_ACTIVE;
            oscEnable_ff <= 1'b1;
            cpuClk_ff    <= 1'b1;
            periphClk_ff <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            oscEnable_ff <= nxt_oscEnable;
            cpuClk_ff    <= nxt_cpuClk;
            periphClk_ff <= nxt_periphClk;
        end
    end

    assign oscEnable       = oscEnable_ff;
    assign cpuClkEnable    = cpuClk_ff;
    assign periphClkEnable = periphClk_ff;

    // Unused upper write data is simply not stored
    wire unusedWr = ^{pwdata[31:8], pwdata[2:0], rdEdge};

endmodule

// >>> sim/sww_chk.sv
`timescale 1ns/1ps
`include "sww_consts.svh"
module sww_chk #(
    parameter int unsigned WAIT_CODE0 = 8,
    parameter int unsigned WAIT_CODE1 = 9,
    parameter int unsigned WAIT_CODE2 = 10,
    parameter int unsigned WAIT_CODE3 = 11,
    parameter int unsigned WAIT_CODE4 = 12,
    parameter int unsigned WAIT_CODE5 = 13
) (
    // Clock and reset
    input wire logic                   ref_clk,
    input wire logic                   reset_n,
    // APB
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`SWW_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Power
    input wire logic                   sleepReq,
    input wire logic                   extIrq,
    input wire logic                   oscEnable,
    input wire logic                   cpuClkEnable,
    input wire logic                   periphClkEnable
);
    // ----------------------------------------
    // Shadow register and wait counter
    // ----------------------------------------
    logic [7:0] shReg_ff;
    int         waitCnt_ff;
    logic       cpuPrev_ff;
    wire        regHit = psel && penable && paddr == `SWW_OFS_STBY_CTRL;
    wire [2:0]  sel = shReg_ff[6:4];
    // Reserved code 110 falls to the longest wait
    wire [31:0] expWait = sel == 3'h7 ? 16 : sel == 3'h0 ? WAIT_CODE0 :
        sel == 3'h1 ? WAIT_CODE1 : sel == 3'h2 ? WAIT_CODE2 : sel == 3'h3 ? WAIT_CODE3 :
        sel == 3'h4 ? WAIT_CODE4 : WAIT_CODE5;
    wire        wakeDone = cpuClkEnable && !cpuPrev_ff && waitCnt_ff != 0;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shReg_ff <= `SWW_STBY_RESET;
            waitCnt_ff <= 0;
            cpuPrev_ff <= 1'b1;
        end else begin
            cpuPrev_ff <= cpuClkEnable;
            if (regHit && pwrite)
                shReg_ff <= {pwdata[7:3], 3'h0};
            waitCnt_ff <= (oscEnable && !periphClkEnable) ? waitCnt_ff + 1 : 0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_read_back: assert property (regHit && !pwrite |-> prdata[7:3] == shReg_ff[7:3])
        else $error("control register read mismatch");
    a_rsv_zero: assert property (regHit && !pwrite |-> prdata[2:0] == 3'h0)
        else $error("reserved low bits not zero");
    a_bad_addr: assert property (psel && penable && paddr > 12'h004 |-> pslverr)
        else $error("unmapped access not refused");
    a_sleep_plain: assert property (sleepReq && cpuClkEnable && !shReg_ff[7]
        |-> ##[1:2] !cpuClkEnable && periphClkEnable && oscEnable) else $error("no plain sleep");
    a_sleep_stby: assert property (sleepReq && cpuClkEnable && shReg_ff[7]
        |-> ##[1:2] !oscEnable) else $error("no standby entry");
    a_stby_dark: assert property (!oscEnable |-> !cpuClkEnable && !periphClkEnable)
        else $error("clocks running in standby");
    a_wait_short: assert property (wakeDone && sel == 3'h7 |-> waitCnt_ff inside {[16:20]})
        else $error("short wait wrong");
    a_wait_count: assert property (wakeDone |->
        waitCnt_ff >= expWait && waitCnt_ff <= expWait + 4) else $error("wake wait wrong");
endmodule

bind sww_standby_ctrl sww_chk #(.WAIT_CODE0(WAIT_CODE0), .WAIT_CODE1(WAIT_CODE1),
    .WAIT_CODE2(WAIT_CODE2), .WAIT_CODE3(WAIT_CODE3), .WAIT_CODE4(WAIT_CODE4),
    .WAIT_CODE5(WAIT_CODE5)) chk (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq), .extIrq(extIrq),
    .oscEnable(oscEnable), .cpuClkEnable(cpuClkEnable), .periphClkEnable(periphClkEnable));

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "sww_consts.svh"
module tb;
    import sww_pkg::*;
    logic ref_clk, reset_n, psel, penable, pwrite, sleepReq, extIrq;
    logic [`SWW_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic pready, pslverr, err, oscEnable, cpuClkEnable, periphClkEnable;
    int nErrors, nTests, n;
    sww_wsel_t code;

    // Short waits keep the run small: code k of 1 to 5 waits 8 + k states, code 0 keeps its real count
    sww_standby_ctrl #(.WAIT_CODE1(9), .WAIT_CODE2(10), .WAIT_CODE3(11),
        .WAIT_CODE4(12), .WAIT_CODE5(13)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq),
        .extIrq(extIrq), .oscEnable(oscEnable), .cpuClkEnable(cpuClkEnable),
        .periphClkEnable(periphClkEnable));

    initial begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic int expWait(input sww_wsel_t c);
        return c == 3'h7 ? 16 : c == 3'h0 ? `SWW_WAIT_CODE0 : 8 + c;
    endfunction

    // Smallest code whose full-length wait reaches ns at 25 ns a state; none reaches 8 ms
    // at this clock, so a crystal setup gets the longest code and needs a slower clock
    function automatic sww_wsel_t settleCode(input longint unsigned ns);
        settleCode = 3'h5;
        for (int k = 4; k >= 0; k--) begin
            if ((longint'(`SWW_WAIT_CODE0) << k) * 25 >= ns)
                settleCode = k[2:0];
        end
    endfunction

    task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (ok !== 1'b1) begin
            nErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Keeping psel up lets the next setup follow without a double assignment
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic keep);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        penable <= 0;
        if (!keep) begin
            psel <= 0;
            @(posedge ref_clk);
        end
    endtask

    task automatic waitFor(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic nap;
        sleepReq <= 1;
        @(posedge ref_clk);
        sleepReq <= 0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic giveVerdict;
        $display("Checks %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        nErrors++;
        giveVerdict();
    end

    initial begin
        {psel, penable, pwrite, sleepReq, extIrq, reset_n} = '0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(32'hc776));
        repeat (8) @(posedge ref_clk);
        reset_n <= 1;
        @(posedge ref_clk);
        apb(0, `SWW_OFS_STBY_CTRL, 0, 0);
        chk(rd === 32'h08, rd, 32'h08);
        repeat (20) begin
            d = $urandom | 32'h8;
            if (d[6:4] == 3'h6)
                d[4] = 1'b0;
            apb(1, `SWW_OFS_STBY_CTRL, d, 1);
            apb(0, `SWW_OFS_STBY_CTRL, 0, 0);
            chk(rd === {24'h0, d[7:3], 3'h0}, rd, {24'h0, d[7:3], 3'h0});
        end
        code = settleCode(2000000);
        apb(1, `SWW_OFS_STBY_CTRL, {24'h0, 1'b0, code, 4'h8}, 1);
        apb(0, `SWW_OFS_STBY_CTRL, 0, 0);
        chk(rd[6:4] === code, rd, {24'h0, 1'b0, code, 4'h8});
        code = settleCode(8000000);
        apb(1, `SWW_OFS_STBY_CTRL, {24'h0, 1'b0, code, 4'h8}, 1);
        apb(0, `SWW_OFS_STBY_CTRL, 0, 0);
        chk(rd[6:4] === code, rd, {24'h0, 1'b0, code, 4'h8});
        apb(1, 12'h008, 32'hff, 1);
        chk(err === 1'b1, err, 1);
        apb(0, 12'h008, 0, 0);
        chk(rd === 0 && err === 1'b1, rd, 0);
        for (int c = 0; c < 8; c++) begin
            code = c[2:0];
            if (code == 3'h6)
                continue;
            apb(1, `SWW_OFS_STBY_CTRL, {24'h0, 1'b1, code, 4'h8}, 0);
            nap();
            chk(oscEnable === 1'b0 && cpuClkEnable === 1'b0, oscEnable, 0);
            extIrq <= 1;
            waitFor(oscEnable, 20);
            chk(oscEnable === 1'b1, oscEnable, 1);
            waitFor(cpuClkEnable, 9000);
            chk(n >= expWait(code) && n <= expWait(code) + 4, n, expWait(code));
            extIrq <= 0;
            @(posedge ref_clk);
        end
        apb(1, `SWW_OFS_STBY_CTRL, 32'h08, 0);
        nap();
        chk(!cpuClkEnable && periphClkEnable && oscEnable, cpuClkEnable, 0);
        apb(0, `SWW_OFS_STATUS, 0, 0);
        chk(rd[1:0] === SWW_SLEEP, rd, SWW_SLEEP);
        extIrq <= 1;
        waitFor(cpuClkEnable, 20);
        chk(cpuClkEnable === 1'b1, cpuClkEnable, 1);
        extIrq <= 0;
        @(posedge ref_clk);
        giveVerdict();
    end
endmodule
